/* File: src/sbi_pkg.sv */
package sbi_pkg;
    localparam int LANE_W = 9;
    localparam int BURST_LEN = 4;
    localparam int BEAT_W = 2;
    localparam int DATA_W_NARROW = 18;
    localparam int DATA_W_WIDE = 36;
    localparam int ADDR_W_NARROW = 20;
    localparam int ADDR_W_WIDE = 19;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST = 2'h3;

    // Gray path through a read burst
    typedef enum logic [2:0] {
        RD_IDLE = 3'h0,
        RD_B0 = 3'h1,
        RD_B1 = 3'h3,
        RD_B2 = 3'h2,
        RD_B3 = 3'h6
    } sbi_rd_state_t;
endpackage

/* File: src/sbi_edge_if.sv */
`timescale 1ns/1ps
interface sbi_edge_if;
    logic k_rise;
    logic kn_rise;
    logic out_pos;
    logic out_neg;

    modport source (output k_rise, output kn_rise, output out_pos, output out_neg);
    modport sink (input k_rise, input kn_rise, input out_pos, input out_neg);
endinterface

/* File: src/sbi_clk_edges.sv */
`timescale 1ns/1ps
module sbi_clk_edges
    import sbi_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst_b,
    // Pin clocks and strap
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clk_mode,
    // Edge pulses
    sbi_edge_if.source edges
);
    logic [4:0] pins;
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic [4:0] s3_reg;
    logic [4:0] lvl_reg;
    logic [4:0] agree;
    logic [4:0] rise;

    assign pins = {single_clk_mode, c_clk_n, c_clk, k_clk_n, k_clk};
    assign agree = ~(s2_reg ^ s3_reg);
    assign rise = agree & s3_reg & ~lvl_reg;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            s3_reg <= 5'h00;
        end
        else
        begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            lvl_reg <= 5'h00;
        else
            lvl_reg <= (agree & s3_reg) | (~agree & lvl_reg);
    end

    // In single clock mode the input clocks also time the read data
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            edges.k_rise <= 1'b0;
            edges.kn_rise <= 1'b0;
            edges.out_pos <= 1'b0;
            edges.out_neg <= 1'b0;
        end
        else
        begin
            edges.k_rise <= rise[0];
            edges.kn_rise <= rise[1];
            edges.out_pos <= lvl_reg[4] ? rise[0] : rise[2];
            edges.out_neg <= lvl_reg[4] ? rise[1] : rise[3];
        end
    end
endmodule

/* File: src/sbi_sram_core.sv */
`timescale 1ns/1ps
// How it works
// - Write data taken on both input clock edges
// - Low write select at K starts write
// - Deselected write port changes memory only to finish a pending burst
// - Low byte masks choose stored bytes
// - Each mask covers one nine-bit lane
// - Mask and data sampled on same edge
// - One address bus sampled at K
// - Address width and four burst arrays
// - Address ignored when its port deselected
// - Read beats on output clock edges
// - Deselected read port tristates outputs
// - Low read select at K starts read
// - Pending read completes, then tristate after C
// - Every read returns four beats
// - Accesses start only on K rising
module sbi_sram_core
    import sbi_pkg::*;
#(
    parameter int DATA_W = DATA_W_NARROW,
    parameter int ADDR_W = ADDR_W_NARROW
)
(
    // System
    input wire logic clk_sys,
    input wire logic rst_b,
    // Pin clocks and strap
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clk_mode,
    // Controls and address
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic [ADDR_W-1:0] addr,
    // Write port
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W/LANE_W-1:0] byte_lane_write_mask_n,
    // Read port
    output logic [DATA_W-1:0] rd_data,
    output logic rd_data_oe_n
);
    localparam int LANES = DATA_W / LANE_W;
    localparam int IN_W = 2 + ADDR_W + DATA_W + LANES;
    localparam int WORDS = 2 ** (ADDR_W + BEAT_W);

    sbi_edge_if edges ();

    sbi_clk_edges u_edges (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .k_clk(k_clk),
        .k_clk_n(k_clk_n),
        .c_clk(c_clk),
        .c_clk_n(c_clk_n),
        .single_clk_mode(single_clk_mode),
        .edges(edges)
    );

    // Inputs ride the same three stages as the clocks so alignment holds
    logic [IN_W-1:0] in_pins;
    logic [IN_W-1:0] in_s1_reg;
    logic [IN_W-1:0] in_s2_reg;
    logic [IN_W-1:0] in_s3_reg;
    logic [IN_W-1:0] in_lvl_reg;
    logic wps_n;
    logic rps_n;
    logic [ADDR_W-1:0] addr_in;
    logic [DATA_W-1:0] d_in;
    logic [LANES-1:0] mask_n_in;

    assign in_pins = {write_port_select_n, read_port_select_n, addr, wr_data,
        byte_lane_write_mask_n};
    assign {wps_n, rps_n, addr_in, d_in, mask_n_in} = in_lvl_reg;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_s1_reg <= '1;
            in_s2_reg <= '1;
            in_s3_reg <= '1;
            in_lvl_reg <= '1;
        end
        else
        begin
            in_s1_reg <= in_pins;
            in_s2_reg <= in_s1_reg;
            in_s3_reg <= in_s2_reg;
            // A bit moves only once the last two stages agree; a split pair holds it
            in_lvl_reg <= (in_s3_reg & ~(in_s2_reg ^ in_s3_reg)) |
                (in_lvl_reg & (in_s2_reg ^ in_s3_reg));
        end
    end

    function automatic logic [ADDR_W+BEAT_W-1:0] word_index(input logic [ADDR_W-1:0] a,
        input logic [1:0] beat);
        word_index = {a, beat};
    endfunction

    // Write port
    logic wr_act_reg;
    logic [1:0] wr_cnt_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic wr_en;
    logic [LANES-1:0] wr_lane_en;

    assign wr_en = wr_act_reg && (edges.k_rise || edges.kn_rise);
    assign wr_lane_en = wr_en ? ~mask_n_in : '0;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_act_reg <= 1'b0;
            wr_cnt_reg <= BEAT_FIRST;
            wr_addr_reg <= '0;
        end
        else if (edges.k_rise && !wps_n)
        begin
            wr_act_reg <= 1'b1;
            wr_cnt_reg <= BEAT_FIRST;
            wr_addr_reg <= addr_in;
        end
        else if (wr_en)
        begin
            wr_cnt_reg <= wr_cnt_reg + 2'h1;
            if (wr_cnt_reg == BEAT_LAST)
                wr_act_reg <= 1'b0;
        end
    end

    logic [DATA_W-1:0] mem [WORDS];

    // Unselected lanes keep their contents
    always_ff @(posedge clk_sys)
    begin
        for (int l = 0; l < LANES; l++)
        begin
            if (wr_lane_en[l])
                mem[word_index(wr_addr_reg, wr_cnt_reg)][l*LANE_W +: LANE_W] <=
                    d_in[l*LANE_W +: LANE_W];
        end
    end

    // Read port
    sbi_rd_state_t rd_state_reg;
    logic rd_pend_reg;
    logic [ADDR_W-1:0] rd_pend_addr_reg;
    logic [ADDR_W-1:0] rd_addr_reg;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_pend_reg <= 1'b0;
            rd_pend_addr_reg <= '0;
        end
        else if (edges.k_rise && !rps_n)
        begin
            rd_pend_reg <= 1'b1;
            rd_pend_addr_reg <= addr_in;
        end
        else if (edges.out_pos && rd_pend_reg && rd_state_reg != RD_B1)
            rd_pend_reg <= 1'b0;
    end

    // A new burst may start on the same C edge that ends the last one
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_state_reg <= RD_IDLE;
            rd_addr_reg <= '0;
        end
        else if (edges.out_pos)
        begin
            case (rd_state_reg)
                RD_B1: rd_state_reg <= RD_B2;
                default:
                begin
                    if (rd_pend_reg)
                    begin
                        rd_state_reg <= RD_B0;
                        rd_addr_reg <= rd_pend_addr_reg;
                    end
                    else
                        rd_state_reg <= RD_IDLE;
                end
            endcase
        end
        else if (edges.out_neg)
        begin
            case (rd_state_reg)
                RD_B0: rd_state_reg <= RD_B1;
                RD_B2: rd_state_reg <= RD_B3;
                default: rd_state_reg <= rd_state_reg;
            endcase
        end
    end

    logic [1:0] rd_beat;
    logic rd_drive;

    always_comb
    begin
        rd_beat = BEAT_FIRST;
        rd_drive = 1'b0;
        if (edges.out_pos && rd_state_reg == RD_B1)
        begin
            rd_beat = 2'h2;
            rd_drive = 1'b1;
        end
        else if (edges.out_pos && rd_pend_reg)
        begin
            rd_beat = BEAT_FIRST;
            rd_drive = 1'b1;
        end
        else if (edges.out_neg && rd_state_reg == RD_B0)
        begin
            rd_beat = 2'h1;
            rd_drive = 1'b1;
        end
        else if (edges.out_neg && rd_state_reg == RD_B2)
        begin
            rd_beat = BEAT_LAST;
            rd_drive = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data <= '0;
            rd_data_oe_n <= 1'b1;
        end
        else if (rd_drive)
        begin
            rd_data <= mem[word_index(rd_beat == BEAT_FIRST && rd_state_reg != RD_B1 ?
                rd_pend_addr_reg : rd_addr_reg, rd_beat)];
            rd_data_oe_n <= 1'b0;
        end
        else if (edges.out_pos && rd_state_reg == RD_B3)
            rd_data_oe_n <= 1'b1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    write_start_a: assert property (edges.k_rise && !wps_n |=> wr_act_reg && wr_cnt_reg == 2'h0)
        else $error("write select did not start a burst");
    no_write_idle_a: assert property (!wr_act_reg |-> wr_lane_en == '0)
        else $error("memory written while write port idle");
    lane_store_a: assert property (wr_en && !mask_n_in[0] |=>
        mem[$past(word_index(wr_addr_reg, wr_cnt_reg))][LANE_W-1:0] == $past(d_in[LANE_W-1:0]))
        else $error("selected lane not stored");
    start_on_k_a: assert property ($rose(wr_act_reg) |-> $past(edges.k_rise))
        else $error("write began off a K edge");
    addr_ignore_a: assert property (edges.k_rise && wps_n && rps_n |=>
        $stable(wr_addr_reg) && $stable(rd_pend_addr_reg))
        else $error("address taken while deselected");
    read_start_a: assert property (edges.k_rise && !rps_n |=> rd_pend_reg)
        else $error("read select not latched");
    burst_step_a: assert property (rd_state_reg == RD_B0 && edges.out_neg |=>
        rd_state_reg == RD_B1 && !rd_data_oe_n)
        else $error("read burst skipped a beat");
    tristate_idle_a: assert property (rd_state_reg == RD_IDLE && !rd_pend_reg
        && edges.out_pos |=> rd_data_oe_n)
        else $error("outputs driven with read port idle");
    drive_edge_a: assert property ($changed(rd_data) |-> $past(edges.out_pos || edges.out_neg))
        else $error("read data moved off an output edge");
endmodule

/* File: bench/sbi_ctrl_model.sv */
`timescale 1ns/1ps
module sbi_ctrl_model
    import sbi_pkg::*;
(
    // Clock and strap
    input wire logic clk_sys,
    input wire logic single_clk_mode,
    // Pin clocks
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    // Controls, address, write data
    output logic write_port_select_n,
    output logic read_port_select_n,
    output logic [ADDR_W_NARROW-1:0] addr,
    output logic [DATA_W_NARROW-1:0] wr_data,
    output logic [1:0] byte_lane_write_mask_n,
    // Read data
    input wire logic [DATA_W_NARROW-1:0] rd_data,
    input wire logic rd_data_oe_n
);
    // K period of 24 system cycles lets every pin edge clear the sync chain
    int ph = 0;
    bit busy = 0;
    assign k_clk = ph < 12;
    assign k_clk_n = !k_clk;
    assign c_clk = ph >= 6 && ph < 18;
    assign c_clk_n = !c_clk;
    initial
    begin
        write_port_select_n = 1'h1;
        read_port_select_n = 1'h1;
        addr = '0;
        wr_data = '0;
        byte_lane_write_mask_n = '0;
    end
    // Idle inputs keep changing so a value wrongly taken cannot hide
    always @(negedge clk_sys)
    begin
        ph <= (ph + 1) % 24;
        if (!busy)
        begin
            addr <= ~addr;
            wr_data <= ~wr_data;
            byte_lane_write_mask_n <= ~byte_lane_write_mask_n;
        end
    end
    task automatic to_ph(input int p);
        do
        begin
            @(negedge clk_sys);
            #1;
        end while (ph != p);
    endtask
    task automatic drive_write(input logic [19:0] a, input logic [71:0] d, input logic [7:0] m);
        busy = 1;
        to_ph(18);
        addr = a;
        write_port_select_n = 1'h0;
        for (int n = 0; n < BURST_LEN; n++)
        begin
            to_ph(n % 2 ? 18 : 6);
            write_port_select_n = 1'h1;
            wr_data = d[n*18 +: 18];
            byte_lane_write_mask_n = m[n*2 +: 2];
        end
        to_ph(6);
        busy = 0;
    endtask
    task automatic drive_read(input logic [19:0] a, output logic [71:0] q,
        output logic [3:0] oe, output logic oe_end);
        busy = 1;
        to_ph(18);
        addr = a;
        read_port_select_n = 1'h0;
        to_ph(6);
        read_port_select_n = 1'h1;
        busy = 0;
        // Sample well after each output edge, before the next one lands
        repeat (single_clk_mode ? 27 : 9) @(negedge clk_sys);
        for (int n = 0; n < BURST_LEN; n++)
        begin
            q[n*18 +: 18] = rd_data;
            oe[n] = rd_data_oe_n;
            repeat (12) @(negedge clk_sys);
        end
        oe_end = rd_data_oe_n;
    endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sbi_pkg::*;
    logic clk_sys;
    logic rst_b;
    logic single_clk_mode;
    logic k_clk;
    logic k_clk_n;
    logic c_clk;
    logic c_clk_n;
    logic wps_n;
    logic rps_n;
    logic [19:0] addr;
    logic [17:0] wr_data;
    logic [1:0] mask_n;
    logic [17:0] rd_data;
    logic rd_data_oe_n;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [17:0] mem_exp [int];
    sbi_sram_core #(.DATA_W(DATA_W_NARROW), .ADDR_W(ADDR_W_NARROW)) sbi_sram_core_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n), .single_clk_mode(single_clk_mode),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n), .addr(addr),
        .wr_data(wr_data), .byte_lane_write_mask_n(mask_n),
        .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));
    sbi_ctrl_model sbi_ctrl_model_inst (
        .clk_sys(clk_sys), .single_clk_mode(single_clk_mode), .k_clk(k_clk),
        .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n), .addr(addr),
        .wr_data(wr_data), .byte_lane_write_mask_n(mask_n),
        .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));
    initial
    begin
        clk_sys = 1'h0;
        forever #25 clk_sys = !clk_sys;
    end
    task end_of_test;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Mirror keeps only lanes whose mask was low on that beat
    task automatic wr(input logic [19:0] a, input logic [71:0] d, input logic [7:0] m);
        sbi_ctrl_model_inst.drive_write(a, d, m);
        for (int n = 0; n < 4; n++)
            for (int l = 0; l < 2; l++)
                if (!m[n*2+l])
                    mem_exp[{a, n[1:0]}][l*9 +: 9] = d[n*18+l*9 +: 9];
    endtask
    task automatic rd_chk(input logic [19:0] a);
        logic [71:0] q;
        logic [71:0] e;
        logic [3:0] oe;
        logic oe_end;
        for (int n = 0; n < 4; n++)
            e[n*18 +: 18] = mem_exp[{a, n[1:0]}];
        sbi_ctrl_model_inst.drive_read(a, q, oe, oe_end);
        check(q, e);
        check(72'(oe), 72'h0);
        check(72'(oe_end), 72'h1);
    endtask
    task t_full;
        wr(20'h00010, {18'h3c0f0, 18'h2aaaa, 18'h15555, 18'h00ff3}, 8'h00);
        rd_chk(20'h00010);
    endtask
    task t_mask;
        wr(20'h00010, {18'h00000, 18'h3ffff, 18'h12345, 18'h0abcd}, 8'h6c);
        rd_chk(20'h00010);
    endtask
    task t_idle;
        check(72'(rd_data_oe_n), 72'h1);
        sbi_ctrl_model_inst.addr = 20'h00010;
        repeat (96) @(negedge clk_sys);
        check(72'(rd_data_oe_n), 72'h1);
        rd_chk(20'h00010);
    endtask
    task t_edge;
        wr(20'hfffff, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00);
        wr(20'h00000, {18'h05555, 18'h16666, 18'h27777, 18'h38888}, 8'h00);
        rd_chk(20'hfffff);
        rd_chk(20'h00000);
    endtask
    task t_single;
        single_clk_mode = 1'h1;
        repeat (48) @(negedge clk_sys);
        rd_chk(20'hfffff);
        single_clk_mode = 1'h0;
        repeat (48) @(negedge clk_sys);
        rd_chk(20'h00010);
    endtask
    initial
    begin
        rst_b = 1'h0;
        single_clk_mode = 1'h0;
        repeat (10) @(negedge clk_sys);
        rst_b = 1'h1;
        repeat (8) @(negedge clk_sys);
        t_full();
        t_mask();
        t_idle();
        t_edge();
        t_single();
        end_of_test();
    end
    // Whole run needs roughly 1050 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule
